// *** inc/dmms_pkg.sv ***
// constants, field layout and types of the dual multiply-subtract datapath
// assumes one 250 MHz core clock and an apb master for software access
package dmms_pkg;
    localparam int DMMS_APB_AW = 8;
    localparam int DMMS_PTR_W = 16;
    // register byte offsets
    localparam logic [7:0] DMMS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] DMMS_ADDR_STAT = 8'h04;
    localparam logic [7:0] DMMS_ADDR_ACC0_LO = 8'h08;
    localparam logic [7:0] DMMS_ADDR_ACC0_HI = 8'h0C;
    localparam logic [7:0] DMMS_ADDR_ACC1_LO = 8'h10;
    localparam logic [7:0] DMMS_ADDR_ACC1_HI = 8'h14;
    localparam logic [7:0] DMMS_ADDR_CPTR = 8'h18;
    localparam logic [7:0] DMMS_ADDR_DPTR = 8'h1C;
    // mode field positions in the control register
    localparam int DMMS_FRAC_BIT = 0;
    localparam int DMMS_MULSAT_BIT = 1;
    localparam int DMMS_RNDSEL_BIT = 2;
    localparam int DMMS_DSAT_BIT = 3;
    localparam int DMMS_WIDE_BIT = 4;
    localparam int DMMS_SIGNX_BIT = 5;
    localparam logic [5:0] DMMS_CTRL_RST = 6'h20;
    localparam logic [15:0] DMMS_PTR_RST = 16'h0000;
    localparam logic [39:0] DMMS_ACC_RST = 40'h00_0000_0000;
    // lowest address above the memory-mapped register page
    localparam logic [15:0] DMMS_MMR_LIMIT = 16'h0060;
    localparam logic [15:0] DMMS_STEP_SPLIT = 16'h0002;
    localparam logic [15:0] DMMS_STEP_ONE = 16'h0001;
    // arithmetic constants
    localparam logic [16:0] DMMS_MIN17 = 17'h18000;
    localparam logic [31:0] DMMS_MUL_SAT = 32'h7FFF_FFFF;
    localparam logic [15:0] DMMS_HALF = 16'h8000;
    localparam logic [39:0] DMMS_MAX40 = 40'h7F_FFFF_FFFF;
    localparam logic [39:0] DMMS_MIN40 = 40'h80_0000_0000;
    localparam logic [39:0] DMMS_MAX32 = 40'h00_7FFF_FFFF;
    localparam logic [39:0] DMMS_MIN32 = 40'hFF_8000_0000;
    typedef enum logic [1:0] {
        DMMS_FORM_DUAL = 2'b01,
        DMMS_FORM_LONG = 2'b10
    } dmms_form_t;
endpackage : dmms_pkg

// *** inc/dmms_lane_if.sv ***
// bundle between the datapath top and one multiply-subtract lane
// assumes the top drives operands and modes, the lane answers combinationally
`timescale 1ns/1ps
`default_nettype none
interface dmms_lane_if;
    logic clk;
    logic rstn;
    logic [15:0] data;
    logic [15:0] coef;
    logic uns_data;
    logic uns_coef;
    logic signx;
    logic frac;
    logic mulsat;
    logic rndsel;
    logic rnd;
    logic wide;
    logic dsat;
    logic [39:0] acc_in;
    logic [39:0] acc_out;
    logic ovf;
    modport top (output clk, rstn, data, coef, uns_data, uns_coef, signx,
        frac, mulsat, rndsel, rnd, wide, dsat, acc_in, input acc_out, ovf);
    modport lane (input clk, rstn, data, coef, uns_data, uns_coef, signx,
        frac, mulsat, rndsel, rnd, wide, dsat, acc_in, output acc_out, ovf);
endinterface : dmms_lane_if
`default_nettype wire

// *** design/dmms_mac_lane.sv ***
// one multiply-subtract lane: widen, multiply, subtract, round, saturate
// assumes operands and accumulator are stable for the whole cycle
`timescale 1ns/1ps
`default_nettype none
module dmms_mac_lane
    import dmms_pkg::*;
(
    dmms_lane_if.lane lif
);
    logic [16:0] opa;
    logic [16:0] opb;
    logic signed [33:0] prod;
    logic mpy_ovf;
    logic [31:0] pshift;
    logic [40:0] diff;
    logic [40:0] rnd_v;
    // widen both inputs to 17 bits
    always_comb begin
        opa = lif.uns_data ? {1'b0, lif.data}
            : {lif.signx & lif.data[15], lif.data};
        opb = lif.uns_coef ? {1'b0, lif.coef}
            : {lif.coef[15], lif.coef};
    end
    assign prod = $signed(opa) * $signed(opb);
    // with both operands sign-extended, only min times min can exceed 32 bits once doubled
    assign mpy_ovf = lif.mulsat & lif.frac & (opa == DMMS_MIN17)
        & (opb == DMMS_MIN17);
    assign pshift = mpy_ovf ? DMMS_MUL_SAT
        : lif.frac ? {prod[30:0], 1'b0} : prod[31:0];
    // one guard bit above the 40 so both overflow tests see the carry
    assign diff = {lif.acc_in[39], lif.acc_in}
        - {{9{pshift[31]}}, pshift};
    // method bit clear: half up; set: ties go to even
    always_comb begin
        rnd_v = diff;
        if (lif.rnd) begin
            if (!(lif.rndsel && diff[15:0] == DMMS_HALF && !diff[16])) begin
                rnd_v = diff + {25'h0000000, DMMS_HALF};
            end
            rnd_v[15:0] = 16'h0000;
        end
    end
    assign lif.ovf = lif.wide ? (rnd_v[40] ^ rnd_v[39])
        : ~((&rnd_v[40:31]) | ~(|rnd_v[40:31]));
    assign lif.acc_out = !(lif.ovf & lif.dsat) ? rnd_v[39:0]
        : lif.wide ? (rnd_v[40] ? DMMS_MIN40 : DMMS_MAX40)
        : (rnd_v[40] ? DMMS_MIN32 : DMMS_MAX32);

    a_uns_zero_fill: assert property (@(posedge lif.clk)
        disable iff (!lif.rstn) lif.uns_data |-> opa[16] == 1'b0)
        else $error("unsigned data not zero-filled");
    a_fractional_shift_mode_even_lsb: assert property (@(posedge lif.clk)
        disable iff (!lif.rstn) (lif.frac && !mpy_ovf) |-> !pshift[0])
        else $error("fractional product lsb set");
endmodule : dmms_mac_lane
`default_nettype wire

// *** design/dmms_addr_gen.sv ***
// coefficient and data pointers with their paired word addresses
// assumes the top pulses i_step once per accepted operation
`timescale 1ns/1ps
`default_nettype none
module dmms_addr_gen
    import dmms_pkg::*;
#(
    parameter int PTR_W = DMMS_PTR_W
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_step,
    input wire logic i_long,
    input wire logic i_coef_postinc,
    input wire logic i_data_postdec,
    input wire logic i_wr_coef,
    input wire logic i_wr_data,
    input wire logic [PTR_W-1:0] i_wdata,
    output logic [PTR_W-1:0] o_coef_ptr,
    output logic [PTR_W-1:0] o_coef_pair,
    output logic [PTR_W-1:0] o_data_ptr,
    output logic [PTR_W-1:0] o_data_pair
);
    // split accesses move a whole long word
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_coef_ptr <= DMMS_PTR_RST;
        end else if (i_step && i_coef_postinc) begin
            o_coef_ptr <= o_coef_ptr + DMMS_STEP_SPLIT;
        end else if (i_wr_coef) begin
            o_coef_ptr <= i_wdata;
        end
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_data_ptr <= DMMS_PTR_RST;
        end else if (i_step && i_data_postdec) begin
            o_data_ptr <= o_data_ptr
                - (i_long ? DMMS_STEP_SPLIT : DMMS_STEP_ONE);
        end else if (i_wr_data) begin
            o_data_ptr <= i_wdata;
        end
    end
    // flipping bit 0 is +1 for even and -1 for odd
    assign o_coef_pair = o_coef_ptr ^ DMMS_STEP_ONE;
    assign o_data_pair = o_data_ptr ^ DMMS_STEP_ONE;

    a_coef_step_two: assert property (@(posedge i_clk)
        disable iff (!i_rstn) (i_step && i_coef_postinc)
        |=> o_coef_ptr == $past(o_coef_ptr) + DMMS_STEP_SPLIT)
        else $error("coefficient pointer did not advance by two");
    a_data_back_two: assert property (@(posedge i_clk)
        disable iff (!i_rstn) (i_step && i_data_postdec && i_long)
        |=> o_data_ptr == $past(o_data_ptr) - DMMS_STEP_SPLIT)
        else $error("long data pointer did not move back by two");
endmodule : dmms_addr_gen
`default_nettype wire

// *** design/dmms_top.sv ***
// dual multiply-subtract datapath with apb access to modes and results
// assumes synchronous operand buses and an apb master on the same clock
`timescale 1ns/1ps
`default_nettype none
module dmms_top
    import dmms_pkg::*;
#(
    parameter int PTR_W = DMMS_PTR_W
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [DMMS_APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // operation request from the decoder
    input wire logic i_op_valid,
    input wire dmms_form_t i_op_form,
    input wire logic i_op_paired,
    input wire logic i_op_rnd,
    input wire logic i_op_wide,
    input wire logic i_uns_data,
    input wire logic i_uns_coef,
    input wire logic i_repeat_active,
    input wire logic i_coef_postinc,
    input wire logic i_data_postdec,
    input wire logic [PTR_W-1:0] i_ymem_addr,
    // operand buses
    input wire logic [15:0] i_data_upper,
    input wire logic [15:0] i_data_lower,
    input wire logic [15:0] i_upper_coef_bus,
    input wire logic [15:0] i_lower_coef_bus,
    output logic o_op_ready,
    output logic o_op_reject,
    output logic [PTR_W-1:0] o_coef_address_bus,
    output logic [PTR_W-1:0] o_coef_pair_addr,
    output logic [PTR_W-1:0] o_data_addr,
    output logic [PTR_W-1:0] o_data_pair_addr,
    output logic [39:0] o_first_accumulator,
    output logic [39:0] o_second_accumulator,
    output logic o_dest_acc_overflow_flag,
    output logic o_second_acc_overflow_flag
);
    logic [5:0] ctrl;
    logic [1:0] ovf_flag;
    logic [39:0] acc [2];
    logic [39:0] lane_out [2];
    logic [1:0] lane_ovf;
    logic [15:0] lane_data [2];
    logic [15:0] lane_coef [2];
    logic wide_eff;
    logic mmr_hit;
    logic reject_cond;
    logic fire;
    logic apb_setup;
    logic wr_en;
    logic [31:0] next_rdata;
    logic next_err;
    logic [1:0] stat_clr;

    // request acceptance
    // a pairing or a bad second operand is refused outright so the
    // decoder never sees a half-executed pair
    assign mmr_hit = (i_op_form == DMMS_FORM_DUAL)
        && (i_ymem_addr < DMMS_MMR_LIMIT);
    assign reject_cond = i_op_valid
        && (i_op_paired || mmr_hit);
    // the repeat flag is not a term here: repeats are accepted
    assign o_op_ready = !i_op_paired && !mmr_hit;
    assign fire = i_op_valid && o_op_ready;

    // refusal is reported one cycle after the request
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_op_reject <= 1'b0;
        end else begin
            o_op_reject <= reject_cond;
        end
    end

    // local wide mode never touches the stored bit
    assign wide_eff = ctrl[DMMS_WIDE_BIT] | i_op_wide;

    // lane 0 is the lower unit, lane 1 the upper unit
    assign lane_data[0] = i_data_lower;
    assign lane_coef[0] = i_lower_coef_bus;
    assign lane_data[1] = i_data_upper;
    assign lane_coef[1] = i_upper_coef_bus;

    // two identical lanes evaluated side by side in one cycle
    for (genvar g = 0; g < 2; g++) begin : g_lane
        dmms_lane_if lif ();
        assign lif.clk = i_clk;
        assign lif.rstn = i_rstn;
        assign lif.data = lane_data[g];
        assign lif.coef = lane_coef[g];
        assign lif.uns_data = i_uns_data;
        assign lif.uns_coef = i_uns_coef;
        assign lif.signx = ctrl[DMMS_SIGNX_BIT];
        assign lif.frac = ctrl[DMMS_FRAC_BIT];
        assign lif.mulsat = ctrl[DMMS_MULSAT_BIT];
        assign lif.rndsel = ctrl[DMMS_RNDSEL_BIT];
        assign lif.rnd = i_op_rnd;
        assign lif.wide = wide_eff;
        assign lif.dsat = ctrl[DMMS_DSAT_BIT];
        assign lif.acc_in = acc[g];
        assign lane_out[g] = lif.acc_out;
        assign lane_ovf[g] = lif.ovf;
        dmms_mac_lane u_lane (
            .lif(lif)
        );
    end

    // pointer unit
    dmms_addr_gen #(
        .PTR_W(PTR_W)
    ) u_addr (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_step(fire),
        .i_long(i_op_form == DMMS_FORM_LONG),
        .i_coef_postinc(i_coef_postinc),
        .i_data_postdec(i_data_postdec),
        .i_wr_coef(wr_en && i_paddr == DMMS_ADDR_CPTR),
        .i_wr_data(wr_en && i_paddr == DMMS_ADDR_DPTR),
        .i_wdata(i_pwdata[PTR_W-1:0]),
        .o_coef_ptr(o_coef_address_bus),
        .o_coef_pair(o_coef_pair_addr),
        .o_data_ptr(o_data_addr),
        .o_data_pair(o_data_pair_addr)
    );

    // apb phases: the slave never stretches the access
    assign apb_setup = i_psel && !i_penable;
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign o_pready = 1'b1;

    // mode register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl <= DMMS_CTRL_RST;
        end else if (wr_en && i_paddr == DMMS_ADDR_CTRL) begin
            ctrl <= i_pwdata[5:0];
        end
    end

    // accumulators: a datapath commit wins over a software write
    // in the same cycle, since the operation already used the old value
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            acc[0] <= DMMS_ACC_RST;
            acc[1] <= DMMS_ACC_RST;
        end else if (fire) begin
            acc[0] <= lane_out[0];
            acc[1] <= lane_out[1];
        end else if (wr_en) begin
            unique case (i_paddr)
                DMMS_ADDR_ACC0_LO: acc[0][31:0] <= i_pwdata;
                DMMS_ADDR_ACC0_HI: acc[0][39:32] <= i_pwdata[7:0];
                DMMS_ADDR_ACC1_LO: acc[1][31:0] <= i_pwdata;
                DMMS_ADDR_ACC1_HI: acc[1][39:32] <= i_pwdata[7:0];
                default: ;
            endcase
        end
    end
    assign o_first_accumulator = acc[0];
    assign o_second_accumulator = acc[1];

    // overflow flags: sticky, write one to clear, a new overflow wins
    assign stat_clr = (wr_en && i_paddr == DMMS_ADDR_STAT)
        ? i_pwdata[1:0] : 2'b00;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ovf_flag <= 2'b00;
        end else begin
            ovf_flag <= (ovf_flag & ~stat_clr)
                | ({2{fire}} & lane_ovf);
        end
    end
    assign o_dest_acc_overflow_flag = ovf_flag[0];
    assign o_second_acc_overflow_flag = ovf_flag[1];

    // read decode; unmapped offsets read zero and flag an error
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (i_paddr)
            DMMS_ADDR_CTRL: next_rdata = {26'h0000000, ctrl};
            DMMS_ADDR_STAT: next_rdata = {30'h00000000, ovf_flag};
            DMMS_ADDR_ACC0_LO: next_rdata = acc[0][31:0];
            DMMS_ADDR_ACC0_HI: next_rdata = {24'h000000, acc[0][39:32]};
            DMMS_ADDR_ACC1_LO: next_rdata = acc[1][31:0];
            DMMS_ADDR_ACC1_HI: next_rdata = {24'h000000, acc[1][39:32]};
            DMMS_ADDR_CPTR: next_rdata = {16'h0000, o_coef_address_bus};
            DMMS_ADDR_DPTR: next_rdata = {16'h0000, o_data_addr};
            default: next_err = 1'b1;
        endcase
    end

    // read data is captured in the setup cycle so it leaves a flop;
    // a commit in that same cycle is therefore seen by the next read
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (apb_setup) begin
            o_prdata <= i_pwrite ? 32'h0000_0000 : next_rdata;
            o_pslverr <= next_err;
        end else if (!i_psel) begin
            o_pslverr <= 1'b0;
        end
    end

    // low half of the lower product as the rules predict it; the
    // saturated min times min case subtracts all ones in the low half
    logic [31:0] lo_mult;
    logic lo_sat;
    logic [15:0] lo_sub;
    assign lo_mult = i_data_lower * i_lower_coef_bus;
    assign lo_sat = ctrl[DMMS_MULSAT_BIT] && ctrl[DMMS_FRAC_BIT]
        && ctrl[DMMS_SIGNX_BIT] && !i_uns_data && !i_uns_coef
        && i_data_lower == 16'h8000 && i_lower_coef_bus == 16'h8000;
    assign lo_sub = lo_sat ? 16'hFFFF
        : ctrl[DMMS_FRAC_BIT] ? {lo_mult[14:0], 1'b0} : lo_mult[15:0];

    // checks on the top-level behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_pair_refused: assert property (
        (i_op_valid && i_op_paired) |-> !o_op_ready ##1 o_op_reject)
        else $error("paired operation was not refused");

    a_mmr_refused: assert property (
        (i_op_valid && i_op_form == DMMS_FORM_DUAL
        && i_ymem_addr < DMMS_MMR_LIMIT) |-> !fire ##1 o_op_reject)
        else $error("second operand reached the register page");

    a_repeat_taken: assert property (
        (i_op_valid && i_repeat_active && !i_op_paired && !mmr_hit)
        |-> fire ##1 !o_op_reject)
        else $error("operation refused inside a repeat loop");

    a_both_commit: assert property (
        fire |=> (acc[0] == $past(lane_out[0]))
        && (acc[1] == $past(lane_out[1])))
        else $error("accumulators did not commit together");

    a_flag_on_ovf: assert property (
        (fire && lane_ovf[0]) |=> o_dest_acc_overflow_flag [*2])
        else $error("lower overflow flag not set or lost");

    a_flag_upper: assert property (
        (fire && lane_ovf[1] && !(wr_en && i_paddr == DMMS_ADDR_STAT))
        |=> o_second_acc_overflow_flag)
        else $error("upper overflow flag not set");

    a_sat_clamp: assert property (
        (fire && lane_ovf[0] && ctrl[DMMS_DSAT_BIT] && !wide_eff)
        |=> (acc[0] == DMMS_MAX32) || (acc[0] == DMMS_MIN32))
        else $error("accumulator not clamped on overflow");

    a_no_sat: assert property (
        (fire && lane_ovf[1] && !ctrl[DMMS_DSAT_BIT])
        |=> (acc[1] != DMMS_MAX40) || ($past(lane_out[1]) == DMMS_MAX40))
        else $error("accumulator clamped with saturation off");

    a_wide_local: assert property (
        (fire && i_op_wide && !(wr_en && i_paddr == DMMS_ADDR_CTRL))
        |=> $stable(ctrl))
        else $error("local wide qualifier changed stored mode");

    a_no_rnd_keep: assert property (
        (fire && !i_op_rnd && !lane_ovf[0])
        |=> acc[0][15:0] == $past(acc[0][15:0] - lo_sub))
        else $error("low half changed without rounding request");

    c_dual_round: cover property (
        fire && i_op_form == DMMS_FORM_DUAL && i_op_rnd);
    c_long_split: cover property (
        fire && i_op_form == DMMS_FORM_LONG && i_data_postdec);
    c_sat_both: cover property (
        fire && lane_ovf[0] && lane_ovf[1] && ctrl[DMMS_DSAT_BIT]);
    c_refuse_then_take: cover property (
        reject_cond ##1 fire);
endmodule : dmms_top
`default_nettype wire

// *** testbench/dmms_mem_model.sv ***
// memory read model: drives the four operand buses from the pointers
// assumes the bench loads words into mem before an operation reads them
`timescale 1ns/1ps
`default_nettype none
module dmms_mem_model (
    input wire logic [15:0] i_data_addr,
    input wire logic [15:0] i_data_pair,
    input wire logic [15:0] i_coef_addr,
    input wire logic [15:0] i_coef_pair,
    output logic [15:0] o_data_upper,
    output logic [15:0] o_data_lower,
    output logic [15:0] o_upper_coef,
    output logic [15:0] o_lower_coef
);
    // one internal store only: coefficients never sit off-chip
    logic [15:0] mem [0:65535];
    // reads answer at once, as internal memory does
    assign o_data_upper = mem[i_data_addr];
    assign o_data_lower = mem[i_data_pair];
    assign o_upper_coef = mem[i_coef_addr];
    assign o_lower_coef = mem[i_coef_pair];
endmodule : dmms_mem_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the dual multiply-subtract datapath
// assumes the memory model supplies operands from the design's pointers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dmms_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, o_prdata;
    logic o_pready, o_pslverr, o_op_ready, o_op_reject, ov0, ov1;
    logic op_valid = 1'b0, paired = 1'b0, rnd = 1'b0, wide = 1'b0;
    logic uns = 1'b0, rpt = 1'b0, step = 1'b0;
    dmms_form_t op_form = DMMS_FORM_DUAL;
    logic [15:0] ymem = 16'h0000, du, dl, cu, cl, ca, cp, da, dp;
    logic [39:0] acc0, acc1;
    int errors = 0;
    int check_count = 0;
    always #2 i_clk = ~i_clk;
    dmms_top i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_op_valid(op_valid), .i_op_form(op_form), .i_op_paired(paired),
        .i_op_rnd(rnd), .i_op_wide(wide), .i_uns_data(uns), .i_uns_coef(uns),
        .i_repeat_active(rpt), .i_coef_postinc(step),
        .i_data_postdec(step), .i_ymem_addr(ymem), .i_data_upper(du),
        .i_data_lower(dl), .i_upper_coef_bus(cu), .i_lower_coef_bus(cl),
        .o_op_ready(o_op_ready), .o_op_reject(o_op_reject),
        .o_coef_address_bus(ca), .o_coef_pair_addr(cp), .o_data_addr(da),
        .o_data_pair_addr(dp), .o_first_accumulator(acc0),
        .o_second_accumulator(acc1), .o_dest_acc_overflow_flag(ov0),
        .o_second_acc_overflow_flag(ov1));
    dmms_mem_model i_mem (.i_data_addr(da), .i_data_pair(dp),
        .i_coef_addr(ca), .i_coef_pair(cp), .o_data_upper(du),
        .o_data_lower(dl), .o_upper_coef(cu), .o_lower_coef(cl));
    // verdict in one place, reached by the main flow or a timeout
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [39:0] s, e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge i_clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            end_of_test();
        end
        q = o_prdata;
        e = o_pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a,
            input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, {8'h00, q}, {8'h00, x});
    endtask : rdc
    task automatic set_acc(input logic [39:0] v0, v1);
        wr(DMMS_ADDR_ACC0_LO, v0[31:0]);
        wr(DMMS_ADDR_ACC0_HI, {24'h000000, v0[39:32]});
        wr(DMMS_ADDR_ACC1_LO, v1[31:0]);
        wr(DMMS_ADDR_ACC1_HI, {24'h000000, v1[39:32]});
    endtask : set_acc
    // words at data pointer, its pair, coef pointer, its pair
    task automatic ld(input logic [15:0] a, b, c, d);
        i_mem.mem[16'h10FC] = a;
        i_mem.mem[16'h10FD] = b;
        i_mem.mem[16'h2002] = c;
        i_mem.mem[16'h2003] = d;
    endtask : ld
    // one operation request; ready sampled in-cycle, reject the cycle after
    task automatic op(input dmms_form_t f, input logic r, m, p,
            input logic [15:0] y, output logic rdy, rej);
        @(posedge i_clk);
        op_valid <= 1'b1;
        op_form <= f;
        rnd <= r;
        wide <= m;
        paired <= p;
        ymem <= y;
        #1 rdy = o_op_ready;
        @(posedge i_clk);
        op_valid <= 1'b0;
        #1 rej = o_op_reject;
    endtask : op
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        rdc("ctrl", DMMS_ADDR_CTRL, 32'h0000_0020);
        chk("pready", {39'h0, o_pready}, 40'h01);
        apb(1'b0, 8'h40, 32'h0, q, e);
        chk("unmapped err", {39'h0, e}, 40'h01);
    endtask : t_regs
    // long form, unsigned operands, post-step pointers, in a repeat loop
    task automatic t_long();
        logic r, j;
        wr(DMMS_ADDR_CPTR, 32'h0000_2000);
        wr(DMMS_ADDR_DPTR, 32'h0000_10FE);
        i_mem.mem[16'h10FE] = 16'hFF00;
        i_mem.mem[16'h10FF] = 16'hFE00;
        i_mem.mem[16'h2000] = 16'h8000;
        i_mem.mem[16'h2001] = 16'h4000;
        set_acc(40'h00_0000_8000, 40'h00_0000_8000);
        chk("coef pair", {24'h0, cp}, 40'h2001);
        chk("data pair", {24'h0, dp}, 40'h10FF);
        uns <= 1'b1;
        rpt <= 1'b1;
        step <= 1'b1;
        op(DMMS_FORM_LONG, 1'b0, 1'b0, 1'b0, 16'h10FE, r, j);
        chk("acc0", acc0, 40'hFF_C080_8000);
        chk("acc1", acc1, 40'hFF_8080_8000);
        chk("ready rpt", {39'h0, r}, 40'h01);
        chk("cptr", {24'h0, ca}, 40'h2002);
        chk("dptr", {24'h0, da}, 40'h10FC);
        chk("flags", {38'h0, ov1, ov0}, 40'h0);
        uns <= 1'b0;
        rpt <= 1'b0;
        step <= 1'b0;
    endtask : t_long
    // dual form operation after loading ctrl and accs; operands are loaded by the caller
    task automatic dual(input logic [31:0] c, input logic [39:0] a0, a1,
            input logic r, m);
        logic y, j;
        wr(DMMS_ADDR_CTRL, c);
        set_acc(a0, a1);
        op(DMMS_FORM_DUAL, r, m, 1'b0, 16'h10FC, y, j);
    endtask : dual
    task automatic t_arith();
        ld(16'h0003, 16'h0003, 16'hFFFF, 16'h0003);
        i_mem.mem[16'h10FC] = 16'hFFFF;
        i_mem.mem[16'h2002] = 16'h0002;
        dual(32'h21, 40'h0, 40'h0, 1'b0, 1'b0);
        chk("fractional_shift_mode sx", acc1, 40'h00_0000_0004);
        chk("fractional_shift_mode lo", acc0, 40'hFF_FFFF_FFEE);
        dual(32'h01, 40'h0, 40'h0, 1'b0, 1'b0);
        chk("no sx", acc1, 40'hFF_FFFC_0004);
        ld(16'h0000, 16'h0000, 16'h0001, 16'h0001);
        dual(32'h20, 40'h8000, 40'h8000, 1'b1, 1'b0);
        chk("rnd0", acc0, 40'h00_0001_0000);
        dual(32'h24, 40'h8000, 40'h8000, 1'b1, 1'b0);
        chk("rnd1", acc1, 40'h0);
        ld(16'h8000, 16'h8000, 16'h8000, 16'h8000);
        dual(32'h23, 40'h0, 40'h0, 1'b0, 1'b0);
        chk("saturate_on_multiply", acc0, 40'hFF_8000_0001);
    endtask : t_arith
    task automatic t_ovf();
        ld(16'h0001, 16'h0001, 16'h0001, 16'h0001);
        dual(32'h28, 40'hFF_8000_0000, 40'h0, 1'b0, 1'b0);
        chk("sat", acc0, 40'hFF_8000_0000);
        chk("ovf", {38'h0, ov1, ov0}, 40'h1);
        rdc("stat", DMMS_ADDR_STAT, 32'h1);
        wr(DMMS_ADDR_STAT, 32'h3);
        dual(32'h28, 40'hFF_8000_0000, 40'h0, 1'b0, 1'b1);
        chk("wide", acc0, 40'hFF_7FFF_FFFF);
        chk("wide ovf", {39'h0, ov0}, 40'h0);
        rdc("ctrl kept", DMMS_ADDR_CTRL, 32'h28);
    endtask : t_ovf
    task automatic t_refuse();
        logic r, j;
        op(DMMS_FORM_LONG, 1'b0, 1'b0, 1'b1, 16'h10FC, r, j);
        chk("pair rdy", {38'h0, r, j}, 40'h1);
        chk("pair acc", acc0, 40'hFF_7FFF_FFFF);
        op(DMMS_FORM_DUAL, 1'b0, 1'b0, 1'b0, 16'h005F, r, j);
        chk("mmr rdy", {38'h0, r, j}, 40'h1);
        op(DMMS_FORM_DUAL, 1'b0, 1'b0, 1'b0, 16'h0060, r, j);
        chk("edge rdy", {38'h0, r, j}, 40'h2);
    endtask : t_refuse
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_regs();
        t_long();
        t_arith();
        t_ovf();
        t_refuse();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
